// ===== cpu_bus_model.sv
module cpu_bus_model (
    input wire logic clk_sys,
    input wire logic [7:0] bus_rdata,
    output logic [31:0] bus_addr,
    output logic [15:0] bus_wdata,
    output logic bus_write,
    output logic bus_read,
    output logic bus_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_addr = 32'h0000_0000;
        bus_wdata = 16'h0000;
        bus_write = 1'b0;
        bus_read = 1'b0;
        bus_word = 1'b0;
    end

    // key in the upper byte, data in the lower byte, one strobe
    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_word <= w;
        bus_write <= 1'b1;
        @(posedge clk_sys);
        bus_write <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_word <= 1'b0;
        bus_read <= 1'b1;
        @(posedge clk_sys);
        bus_read <= 1'b0;
        @(posedge clk_sys);
        d = bus_rdata;
    endtask
endmodule

// ===== test_watchdog_interval_timer.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module test_watchdog_interval_timer;
    import watchdog_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_owned = 1'b0;
    logic standby_request = 1'b0;
    logic [3:0] wake = 4'h0;
    logic wake_nmi = 1'b0;
    logic [31:0] bus_addr;
    logic [15:0] bus_wdata;
    logic bus_write, bus_read, bus_word;
    logic [7:0] bus_rdata;
    logic alarm_n, interval_irq, chip_reset_out, chip_reset_kind;
    logic port_regs_init, standby_active, clock_resume;
    int fails = 0;
    int checks_done = 0;
    int n, m, k;
    localparam logic [31:0] CT = ADDR_TIMER_CONTROL;
    localparam logic [31:0] RR = ADDR_RESET_CONTROL_READ;

    always #2 clk_sys = ~clk_sys;

    cpu_bus_model u_cpu_bus_model (.clk_sys(clk_sys), .bus_rdata(bus_rdata),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_word(bus_word));
    watchdog_interval_timer u_watchdog_interval_timer (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_word(bus_word), .bus_owned(bus_owned),
        .standby_request(standby_request), .wakeup_nmi(wake_nmi), .external_wakeup_lines(wake),
        .bus_rdata(bus_rdata), .overflow_alarm_out_n(alarm_n), .interval_irq(interval_irq),
        .chip_reset_out(chip_reset_out), .chip_reset_kind(chip_reset_kind),
        .port_regs_init(port_regs_init), .standby_active(standby_active),
        .clock_resume(clock_resume));

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        u_cpu_bus_model.wr(a, d, 1'b1);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_cpu_bus_model.rd(a, v);
        `CHK(v, e)
    endtask

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_access;
        rchk(CT, 8'h18);
        rchk(RR, 8'h1F);
        rchk(ADDR_RESET_CONTROL_WRITE, 8'h00);
        u_cpu_bus_model.wr(CT, 16'hA567, 1'b0);
        u_cpu_bus_model.wr(ADDR_RESET_CONTROL_WRITE, 16'h5A60, 1'b0);
        wr(CT, 16'h1267);
        rchk(CT, 8'h18);
        rchk(RR, 8'h1F);
        wr(CT, 16'hA527);
        wr(CT, 16'h5A80);
        rchk(CT, 8'h3F);
        rchk(ADDR_TIMER_COUNT, 8'h80);
        wr(CT, 16'hA507);
        rchk(ADDR_TIMER_COUNT, 8'h00);
    endtask

    task automatic check_interval;
        wr(CT, 16'hA520);
        wr(CT, 16'h5AFD);
        for (n = 0; n < 20 && interval_irq !== 1'b1; n++) @(posedge clk_sys);
        `CHK(n < 20, 1'b1)
        repeat (10) @(posedge clk_sys);
        `CHK(interval_irq, 1'b1)
        rchk(CT, 8'hB8);
        // handler clears the flag after reading it as one
        wr(CT, 16'hA500);
        @(posedge clk_sys);
        `CHK(interval_irq, 1'b0)
    endtask

    task automatic check_watchdog(input logic kind, input logic owned);
        bus_owned <= owned;
        wr(ADDR_RESET_CONTROL_WRITE, {8'h5A, 1'b0, 1'b1, kind, 5'h00});
        rchk(RR, {2'b01, kind, 5'h1F});
        wr(CT, 16'hA560);
        wr(CT, 16'h5AFD);
        for (n = 0; n < 20 && alarm_n !== 1'b0; n++) @(posedge clk_sys);
        `CHK(chip_reset_out, !kind)
        n = 0;
        m = 0;
        k = 0;
        for (int i = 0; i < 600; i++) begin
            n += (alarm_n === 1'b0);
            m += (chip_reset_out === 1'b1);
            k |= (chip_reset_out === 1'b1 && chip_reset_kind === 1'b1);
            @(posedge clk_sys);
        end
        `CHK(n, ALARM_CYCLES)
        `CHK(m > 500, !kind || owned)
        `CHK(m == 0, kind && !owned)
        `CHK(k, int'(kind && owned))
        `CHK(port_regs_init, 1'b0)
        rchk(RR, {2'b11, kind, 5'h1F});
        rchk(CT, 8'h18);
        wr(ADDR_RESET_CONTROL_WRITE, 16'hA500);
        rchk(RR, {2'b01, kind, 5'h1F});
    endtask

    task automatic check_standby;
        for (int i = 0; i < 2; i++) begin
            wr(CT, i == 0 ? 16'hA520 : 16'hA500);
            @(posedge clk_sys);
            standby_request <= 1'b1;
            @(posedge clk_sys);
            standby_request <= 1'b0;
            repeat (2) @(posedge clk_sys);
            `CHK(standby_active, i == 1)
        end
        for (int j = 0; j < 2; j++) begin
            if (j == 1) begin
                standby_request <= 1'b1;
                @(posedge clk_sys);
                standby_request <= 1'b0;
                repeat (2) @(posedge clk_sys);
                `CHK(standby_active, 1'b1)
            end
            wake <= j == 0 ? 4'h2 : 4'h0;
            wake_nmi <= j == 1;
            @(posedge clk_sys);
            wake <= 4'h0;
            wake_nmi <= 1'b0;
            for (n = 0; n < 700 && clock_resume !== 1'b1; n++) @(posedge clk_sys);
            `CHK(n > 500 && n < 530, 1'b1)
            `CHK(standby_active, 1'b0)
        end
    endtask

    task automatic check_ext_reset;
        wr(ADDR_RESET_CONTROL_WRITE, 16'h5A40);
        wr(CT, 16'hA560);
        wr(CT, 16'h5AFD);
        for (n = 0; n < 20 && alarm_n !== 1'b0; n++) @(posedge clk_sys);
        `CHK(chip_reset_out, 1'b1)
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(port_regs_init, 1'b1)
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK({alarm_n, chip_reset_out}, 2'b10)
        rchk(RR, 8'h1F);
    endtask

    initial begin
        #1;
        `CHK(port_regs_init, 1'b1)
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        check_access();
        check_interval();
        check_watchdog(1'b0, 1'b0);
        check_watchdog(1'b1, 1'b0);
        check_watchdog(1'b1, 1'b1);
        check_standby();
        check_ext_reset();
        stop_test();
    end

    initial begin
        #100000;
        fails++;
        stop_test();
    end
endmodule

// ===== watchdog_interval_timer.sv
module watchdog_interval_timer
    import watchdog_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [31:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic bus_word,
    input wire logic bus_owned,
    input wire logic standby_request,
    input wire logic wakeup_nmi,
    input wire logic [3:0] external_wakeup_lines,
    output logic [7:0] bus_rdata,
    output logic overflow_alarm_out_n,
    output logic interval_irq,
    output logic chip_reset_out,
    output logic chip_reset_kind,
    output logic port_regs_init,
    output logic standby_active,
    output logic clock_resume
);
    typedef struct packed {
        logic [12:0] pre;
        logic [7:0] count;
        logic ovf;
        logic mode;
        logic run;
        logic [2:0] cks;
        logic ovf_seen;
        logic watchdog_overflow_flag;
        logic chip_reset_allow;
        logic reset_kind_select;
        logic [7:0] alarm_cnt;
        logic [9:0] rst_cnt;
        logic [9:0] rst_len;
        logic rst_kind;
        logic manual_go;
        logic standby;
        logic waking;
        logic resume;
        logic [7:0] rdata;
    } state_t;

    localparam state_t STATE_RESET = '0;
    localparam logic [7:0] ALARM_LOAD = 8'(ALARM_CYCLES);
    localparam logic [9:0] RESET_LOAD = 10'(CHIP_RESET_CYCLES);

    state_t s;
    state_t next_s;
    logic tick;
    logic counting;
    logic wr_count;
    logic wr_control;
    logic wr_reset_ctl;
    logic ovf_evt;
    logic wd_ovf;
    logic it_ovf;
    logic wake_evt;

    always_comb begin
        tick = (s.pre & DIV_MASK[s.cks]) == DIV_MASK[s.cks]; // [R24]
        counting = s.run | s.waking;
        // only full-word writes reach the timer registers
        wr_count = bus_write && bus_word && bus_addr == ADDR_TIMER_CONTROL
                   && bus_wdata[15:8] == KEY_COUNT; // [R13] [R14]
        wr_control = bus_write && bus_word && bus_addr == ADDR_TIMER_CONTROL
                     && bus_wdata[15:8] == KEY_CONTROL; // [R13] [R14]
        wr_reset_ctl = bus_write && bus_word && bus_addr == ADDR_RESET_CONTROL_WRITE; // [R15]
        // a write in the tick cycle replaces the step and its overflow
        ovf_evt = counting && tick && !wr_count && s.count == COUNT_TOP; // [R19] [R26]
        wd_ovf = ovf_evt && s.mode && s.run; // [R1]
        it_ovf = ovf_evt && !s.mode && s.run; // [R8]
        wake_evt = wakeup_nmi || (|external_wakeup_lines);

        next_s = s;
        next_s.pre = 13'(s.pre + 13'h0001);
        next_s.resume = 1'b0;

        if (!counting) begin
            next_s.count = COUNT_RESET; // [R25]
        end else if (wr_count) begin
            next_s.count = bus_wdata[7:0]; // [R19]
        end else if (tick) begin
            next_s.count = 8'(s.count + 8'h01); // [R26]
        end

        if (wr_control) begin
            next_s.mode = bus_wdata[TCS_MODE_BIT];
            next_s.run = bus_wdata[TCS_RUN_BIT];
            next_s.cks = bus_wdata[2:0];
            // flag clears only by writing 0 after it was read as 1
            if (!bus_wdata[TCS_OVF_BIT] && s.ovf_seen) begin
                next_s.ovf = 1'b0;
            end
            next_s.ovf_seen = 1'b0;
        end
        if (bus_read && bus_addr == ADDR_TIMER_CONTROL && s.ovf) begin
            next_s.ovf_seen = 1'b1;
        end
        if (it_ovf) begin
            next_s.ovf = 1'b1; // [R11]
        end

        if (wr_reset_ctl && bus_wdata[15:8] == KEY_FLAG_CLEAR
            && bus_wdata[7:0] == FLAG_CLEAR_DATA) begin
            next_s.watchdog_overflow_flag = 1'b0; // [R16]
        end
        if (wr_reset_ctl && bus_wdata[15:8] == KEY_RESET_FIELDS) begin
            next_s.chip_reset_allow = bus_wdata[RCS_ALLOW_BIT]; // [R17]
            next_s.reset_kind_select = bus_wdata[RCS_KIND_BIT]; // [R17]
        end

        if (s.alarm_cnt != 8'h00) begin
            next_s.alarm_cnt = 8'(s.alarm_cnt - 8'h01);
        end
        if (s.rst_cnt != 10'h000) begin
            next_s.rst_cnt = 10'(s.rst_cnt - 10'h001);
        end
        // cycles the chip reset has stood so far, watched by the length checks
        if (chip_reset_out) begin
            next_s.rst_len = 10'(s.rst_len + 10'h001);
        end else begin
            next_s.rst_len = 10'h000;
        end
        // manual reset is taken only once the bus is ours inside the window
        if (s.rst_cnt != 10'h000 && s.rst_kind == RESET_MANUAL && bus_owned) begin
            next_s.manual_go = 1'b1; // [R23]
        end
        if (s.rst_cnt == 10'h001) begin
            next_s.manual_go = 1'b0; // [R23]
        end

        if (wd_ovf) begin
            next_s.watchdog_overflow_flag = 1'b1; // [R12]
            next_s.alarm_cnt = ALARM_LOAD; // [R2]
            // counter and control fall back to reset values in every case
            next_s.count = COUNT_RESET; // [R22]
            next_s.ovf = 1'b0; // [R22]
            next_s.mode = 1'b0; // [R22]
            next_s.run = 1'b0; // [R22]
            next_s.cks = 3'b000; // [R22]
            next_s.ovf_seen = 1'b0;
            if (s.chip_reset_allow) begin
                next_s.rst_cnt = RESET_LOAD; // [R3]
                next_s.rst_kind = s.reset_kind_select; // [R4] [R5]
                next_s.manual_go = 1'b0;
            end
        end

        if (standby_request && !s.run && !s.standby) begin
            next_s.standby = 1'b1; // [R9]
        end
        if (s.standby && !s.waking && wake_evt) begin
            next_s.waking = 1'b1; // [R10]
        end
        if (s.waking && ovf_evt) begin
            next_s.standby = 1'b0; // [R10]
            next_s.waking = 1'b0; // [R10]
            next_s.resume = 1'b1; // [R10]
        end

        if (bus_read) begin
            case (bus_addr) // [R18]
                ADDR_TIMER_CONTROL: next_s.rdata = {s.ovf, s.mode, s.run, 2'b00, s.cks}
                                                   | TCS_RESERVED_ONES;
                ADDR_TIMER_COUNT: next_s.rdata = s.count;
                ADDR_RESET_CONTROL_READ: next_s.rdata = {s.watchdog_overflow_flag, s.chip_reset_allow, s.reset_kind_select, 5'b00000}
                                                        | RCS_RESERVED_ONES;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= STATE_RESET; // [R6]
        end else begin
            s <= next_s;
        end
    end

    assign bus_rdata = s.rdata;
    assign overflow_alarm_out_n = s.alarm_cnt == 8'h00; // [R2]
    assign interval_irq = s.ovf; // [R11]
    assign chip_reset_out = s.rst_cnt != 10'h000
                            && (s.rst_kind == RESET_POWER_ON || s.manual_go); // [R3] [R23]
    assign chip_reset_kind = s.rst_kind;
    // port-side registers are initialised by the external reset alone
    assign port_regs_init = sys_rst; // [R7]
    assign standby_active = s.standby;
    assign clock_resume = s.resume;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence alarm_window;
        (!overflow_alarm_out_n throughout ##127 1'b1) ##1 overflow_alarm_out_n;
    endsequence

    sequence wake_restart;
        s.count == COUNT_RESET ##1 standby_active;
    endsequence

    alarm_length_a: assert property ($fell(overflow_alarm_out_n) |-> alarm_window) // [R2]
        else $error("alarm low time is not 128 cycles");

    reset_length_a: assert property ( // [R3]
        $fell(chip_reset_out) && chip_reset_kind == RESET_POWER_ON && !$past(sys_rst)
        |-> s.rst_len == RESET_LOAD)
        else $error("power-on chip reset is not 512 cycles");

    reset_bound_a: assert property (chip_reset_out |-> s.rst_len < RESET_LOAD) // [R3]
        else $error("chip reset held longer than 512 cycles");

    reset_with_alarm_a: assert property ( // [R3]
        $fell(overflow_alarm_out_n) && $past(s.chip_reset_allow) && !$past(s.reset_kind_select)
        |-> $rose(chip_reset_out))
        else $error("chip reset not raised with the alarm");

    reset_kind_a: assert property ( // [R4]
        $rose(s.rst_cnt != 10'h000) |-> chip_reset_kind == $past(s.reset_kind_select))
        else $error("chip reset kind does not follow the select bit");

    flag_with_alarm_a: assert property ($fell(overflow_alarm_out_n) |-> s.watchdog_overflow_flag) // [R12]
        else $error("watchdog flag not set with the alarm");

    wd_clears_timer_a: assert property (wd_ovf |=> !s.run && !s.mode // [R22]
        && s.count == COUNT_RESET)
        else $error("watchdog overflow left the timer running");

    interval_irq_a: assert property (it_ovf |=> interval_irq && overflow_alarm_out_n) // [R8]
        else $error("interval overflow did not request the interrupt");

    no_standby_run_a: assert property (s.run |=> !$rose(standby_active)) // [R9]
        else $error("standby entered while the timer runs");

    wake_exit_a: assert property (s.waking && ovf_evt // [R10]
        |=> !standby_active && clock_resume ##1 !clock_resume)
        else $error("standby not left on counter rollover");

    count_hold_a: assert property (!s.run && !s.waking |=> s.count == COUNT_RESET) // [R25]
        else $error("counter not held at zero while stopped");

    count_write_a: assert property (wr_count && counting // [R19]
        |=> s.count == $past(bus_wdata[7:0]))
        else $error("keyed counter write lost");

    byte_write_a: assert property (bus_write && !bus_word && !wd_ovf // [R13]
        |=> $stable(s.cks) && $stable(s.mode) && $stable(s.chip_reset_allow) && $stable(s.reset_kind_select))
        else $error("byte write changed a keyed register");

    allow_write_a: assert property ( // [R17]
        wr_reset_ctl && bus_wdata[15:8] == KEY_RESET_FIELDS && !wd_ovf
        |=> s.chip_reset_allow == $past(bus_wdata[RCS_ALLOW_BIT]) && $stable(s.watchdog_overflow_flag))
        else $error("reset field write wrong");

    count_read_a: assert property ( // [R18]
        bus_read && bus_addr == ADDR_TIMER_COUNT |=> bus_rdata == $past(s.count))
        else $error("counter read returned wrong value");

    manual_owned_a: assert property ( // [R23]
        $rose(chip_reset_out) && chip_reset_kind == RESET_MANUAL |-> $past(bus_owned))
        else $error("manual reset taken without the bus");

    flag_clear_a: assert property ( // [R16]
        wr_reset_ctl && bus_wdata == {KEY_FLAG_CLEAR, FLAG_CLEAR_DATA} && !wd_ovf
        |=> !s.watchdog_overflow_flag && $stable(s.chip_reset_allow) && $stable(s.reset_kind_select))
        else $error("flag clear write wrong");

    wd_no_irq_a: assert property (wd_ovf |=> !interval_irq && s.watchdog_overflow_flag) // [R1] [R12]
        else $error("watchdog overflow raised the interval request");

    control_key_a: assert property ( // [R14]
        wr_control && !wd_ovf |=> s.run == $past(bus_wdata[TCS_RUN_BIT])
        && s.cks == $past(bus_wdata[2:0]))
        else $error("keyed control write lost");

    control_read_a: assert property ( // [R18]
        bus_read && bus_addr == ADDR_TIMER_CONTROL
        |=> bus_rdata[TCS_RUN_BIT] == $past(s.run) && bus_rdata[4:3] == 2'b11)
        else $error("control read returned wrong value");

    reset_read_a: assert property ( // [R18]
        bus_read && bus_addr == ADDR_RESET_CONTROL_READ
        |=> bus_rdata[RCS_WATCHDOG_OVERFLOW_FLAG_BIT] == $past(s.watchdog_overflow_flag) && bus_rdata[4:0] == 5'h1F)
        else $error("reset control read returned wrong value");

    standby_enter_a: assert property ( // [R9]
        standby_request && !s.run && !s.standby |=> standby_active)
        else $error("standby refused while the timer is stopped");

    wake_start_a: assert property ($rose(s.waking) |-> wake_restart) // [R10]
        else $error("wake-up did not restart the counter from zero");

    overflow_wrap_a: assert property (ovf_evt |=> s.count == COUNT_RESET) // [R26]
        else $error("counter did not wrap to zero on overflow");

    interval_hold_a: assert property ( // [R11]
        interval_irq && !wr_control && !wd_ovf |=> interval_irq)
        else $error("interval request dropped while the flag is set");
endmodule

// ===== watchdog_pkg.sv
// Functional notes
// [R1] watchdog mode runs when mode select and run bits are both one
// [R2] watchdog overflow drives the active-low alarm output for exactly 128 cycles
// [R3] with reset allowed, overflow also raises a 512-cycle chip reset with the alarm
// [R4] reset kind select picks power-on or manual chip reset on overflow
// [R5] reset kind 0 means power-on reset, 1 means manual reset
// [R6] external reset wins over a coinciding overflow and clears the watchdog flag
// [R7] watchdog reset never initialises port enable, pin function or port registers
// [R8] interval mode requests an interrupt on every counter overflow
// [R9] standby entry is refused while the run bit is one
// [R10] wake-up restarts the counter; rollover FF to 00 resumes clocks, leaves standby
// [R11] interval overflow sets the flag; request stays while flag is one
// [R12] watchdog overflow sets the watchdog flag together with the alarm
// [R13] counter and control register accept only word writes; byte writes ignored
// [R14] shared word address; key 5A loads counter, key A5 loads control
// [R15] reset control register is written only by word access at FFFF8612
// [R16] key A5 with data 00 clears watchdog flag, keeps allow and kind bits
// [R17] key 5A copies data bit 6 to allow, bit 5 to kind
// [R18] byte reads at 8610, 8611, 8613 return control, counter, reset control
// [R19] a counter write in the increment cycle wins; that increment is dropped
// [R20] software stops the timer before changing the divider select
// [R21] software stops the timer before switching between interval and watchdog mode
// [R22] overflow without reset allow still clears the counter and control register
// [R23] manual reset waits for the bus; ignored if the wait reaches 512 cycles
// [R24] divider select chooses one of eight prescaler taps, phi/2 to phi/8192
// [R25] run bit zero holds the counter at 00; one starts counting
// [R26] 8-bit up-counter, one step per tick, overflow on wrap from FF to 00
package watchdog_pkg;
    localparam logic [31:0] ADDR_TIMER_CONTROL = 32'hFFFF8610;
    localparam logic [31:0] ADDR_TIMER_COUNT = 32'hFFFF8611;
    localparam logic [31:0] ADDR_RESET_CONTROL_WRITE = 32'hFFFF8612;
    localparam logic [31:0] ADDR_RESET_CONTROL_READ = 32'hFFFF8613;
    localparam logic [7:0] KEY_COUNT = 8'h5A;
    localparam logic [7:0] KEY_CONTROL = 8'hA5;
    localparam logic [7:0] KEY_FLAG_CLEAR = 8'hA5;
    localparam logic [7:0] KEY_RESET_FIELDS = 8'h5A;
    localparam logic [7:0] FLAG_CLEAR_DATA = 8'h00;
    localparam int TCS_OVF_BIT = 7;
    localparam int TCS_MODE_BIT = 6;
    localparam int TCS_RUN_BIT = 5;
    localparam int RCS_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
    localparam int RCS_ALLOW_BIT = 6;
    localparam int RCS_KIND_BIT = 5;
    localparam logic [7:0] TCS_RESERVED_ONES = 8'h18;
    localparam logic [7:0] RCS_RESERVED_ONES = 8'h1F;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam int ALARM_CYCLES = 128;
    localparam int CHIP_RESET_CYCLES = 512;
    localparam logic RESET_POWER_ON = 1'b0;
    localparam logic RESET_MANUAL = 1'b1;
    // tap masks for phi/2,64,128,256,512,1024,4096,8192
    localparam logic [12:0] DIV_MASK [0:7] = '{13'h0001, 13'h003F, 13'h007F, 13'h00FF,
                                               13'h01FF, 13'h03FF, 13'h0FFF, 13'h1FFF};
endpackage
